// ===== verilog/pin_mux_consts.svh
/*
 * reset values, pin positions and synchroniser reset level for the shared-pin
 * function multiplexer of port D and port E.
 * assumes: included by its bare name after the package; definitions only.
 */
`ifndef PIN_MUX_CONSTS_SVH
`define PIN_MUX_CONSTS_SVH

// pin counts of the two shared groups
`define PORT_D_WIDTH 8
`define PORT_E_WIDTH 2
`define CS_COUNT 6

// pin positions of the serial lines
`define D_TX_BIT 6
`define D_RX_BIT 7
`define E_TX_BIT 0
`define E_RX_BIT 1

// function select: 1 = peripheral, 0 = general purpose
`define PORT_D_FUNC_RST 8'hc0
`define PORT_E_FUNC_RST 2'h3

// pull-up registers start with every pull-up enabled
`define PULLUP_D_RST 8'hff
`define PULLUP_E_RST 2'h3

// general-purpose direction and data start as inputs, low
`define DIR_D_RST 8'h00
`define DIR_E_RST 2'h0
`define DATA_D_RST 8'h00
`define DATA_E_RST 2'h0

// pins idle high through their pull-ups, so filtered inputs start high
`define SYNC_RST_LEVEL 1'b1

`endif

// ===== verilog/pin_mux_pkg.sv
/*
 * types shared by the pin multiplexer and its users.
 * assumes: compiled before every other file of the block.
 */
`default_nettype none

package pin_mux_pkg;

	// which configuration register a write lands in
	typedef enum logic [2:0] {
		TGT_FUNC_D = 3'h0,
		TGT_DIR_D = 3'h1,
		TGT_DATA_D = 3'h2,
		TGT_PULL_D = 3'h3,
		TGT_FUNC_E = 3'h4,
		TGT_DIR_E = 3'h5,
		TGT_DATA_E = 3'h6,
		TGT_PULL_E = 3'h7
	} cfg_target_t;

	// one configuration write, taken in the cycle en is high
	typedef struct packed {
		logic en;
		cfg_target_t target;
		logic [7:0] data;
	} cfg_write_t;

	// chip selects from the external memory interface
	typedef struct packed {
		logic [5:0] select_n;
		logic bus_active;
		logic idle_bus_drive_bit;
	} emi_cs_t;

endpackage

`default_nettype wire

// ===== verilog/pin_input_sync.sv
/*
 * three-flop synchroniser with agreement filter for pin inputs.
 * assumes: raw comes from package pins, asynchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_consts.svh"

module pin_input_sync #(
	parameter int WIDTH = 8
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [WIDTH-1:0] raw,
	output logic [WIDTH-1:0] clean
);

	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] second;
	logic [WIDTH-1:0] third;
	wire [WIDTH-1:0] agree = ~(second ^ third);
	wire [WIDTH-1:0] next_clean = (agree & second) | (~agree & clean);

	// meta feeds only second; a level counts once second and third agree
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meta <= {WIDTH{`SYNC_RST_LEVEL}};
			second <= {WIDTH{`SYNC_RST_LEVEL}};
			third <= {WIDTH{`SYNC_RST_LEVEL}};
			clean <= {WIDTH{`SYNC_RST_LEVEL}};
		end
		else
		begin
			meta <= raw;
			second <= meta;
			third <= second;
			clean <= next_clean;
		end
	end

endmodule // pin_input_sync

`default_nettype wire

// ===== verilog/port_d_e_pin_function_mux.sv
/*
 * pin function multiplexer for eight port D pins and two port E pins.
 * low six port D pins: general purpose or region chip selects 2..7;
 * port D 6/7: serial port one tx/rx; port E 0/1: serial port zero tx/rx.
 * assumes: pads resolve out/oe_n/pull-up; oe_n low means the pad drives.
 * configuration arrives as single-cycle writes on cfg; no register bus.
 */
// What this block does
// RULE1: low six port D pins have own direction
// RULE2: low six pins may carry region chip selects
// RULE3: reset leaves those six pins general purpose
// RULE4: idle chip selects float or drive per bit
// RULE5: software should set idle drive bit to one
// RULE6: port D pull-up bit n gates pin n
// RULE7: serial zero tx on port E 0
// RULE8: serial zero rx on port E 1
// RULE9: port E pull-up bits 0,1 gate serial zero
// RULE10: serial one tx on port D 6
// RULE11: serial one rx on port D 7
// RULE12: port D pull-up bits 6,7 gate serial one
// RULE13: function-select bits; pull-ups reset to enabled
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_consts.svh"

module port_d_e_pin_function_mux
	import pin_mux_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire cfg_write_t cfg,
	input wire emi_cs_t external_memory_interface,
	input wire logic serial_zero_tx,
	input wire logic serial_one_tx,
	output logic serial_zero_rx,
	output logic serial_one_rx,
	input wire logic [7:0] port_d_pin_in,
	output logic [7:0] port_d_pin_out,
	output logic [7:0] port_d_pin_oe_n,
	output logic [7:0] port_d_pin_pullup_en,
	input wire logic [1:0] port_e_pin_in,
	output logic [1:0] port_e_pin_out,
	output logic [1:0] port_e_pin_oe_n,
	output logic [1:0] port_e_pin_pullup_en,
	output logic [7:0] port_d_gpio_level,
	output logic [1:0] port_e_gpio_level,
	output logic [7:0] port_d_func,
	output logic [7:0] port_d_pullup_reg,
	output logic [1:0] port_e_func,
	output logic [1:0] port_e_pullup_reg
);

	////////////////////////////////////////////////////////////////////////
	// configuration registers

	logic [7:0] port_d_dir;
	logic [7:0] port_d_data;
	logic [1:0] port_e_dir;
	logic [1:0] port_e_data;

	// a write replaces the whole register it targets
	function automatic logic [7:0] write_byte(
		input cfg_write_t w,
		input cfg_target_t t,
		input logic [7:0] cur
	);
		write_byte = (w.en && w.target == t) ? w.data : cur;
	endfunction

	wire [7:0] next_d_func = write_byte(cfg, TGT_FUNC_D, port_d_func);
	wire [7:0] next_d_dir = write_byte(cfg, TGT_DIR_D, port_d_dir);
	wire [7:0] next_d_data = write_byte(cfg, TGT_DATA_D, port_d_data);
	wire [7:0] next_d_pull = write_byte(cfg, TGT_PULL_D, port_d_pullup_reg);
	wire [7:0] next_e_func_w =
		write_byte(cfg, TGT_FUNC_E, {6'h00, port_e_func});
	wire [7:0] next_e_dir_w =
		write_byte(cfg, TGT_DIR_E, {6'h00, port_e_dir});
	wire [7:0] next_e_data_w =
		write_byte(cfg, TGT_DATA_E, {6'h00, port_e_data});
	wire [7:0] next_e_pull_w =
		write_byte(cfg, TGT_PULL_E, {6'h00, port_e_pullup_reg});

	// port D registers; reset puts chip-select pins in gpio mode
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			port_d_func <= `PORT_D_FUNC_RST; // [RULE3] [RULE13]
			port_d_dir <= `DIR_D_RST;
			port_d_data <= `DATA_D_RST;
			port_d_pullup_reg <= `PULLUP_D_RST; // [RULE13]
		end
		else
		begin
			port_d_func <= next_d_func; // [RULE13]
			port_d_dir <= next_d_dir; // [RULE1]
			port_d_data <= next_d_data;
			port_d_pullup_reg <= next_d_pull;
		end
	end

	// port E registers; only the low two bits of a write are kept
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			port_e_func <= `PORT_E_FUNC_RST; // [RULE7] [RULE8]
			port_e_dir <= `DIR_E_RST;
			port_e_data <= `DATA_E_RST;
			port_e_pullup_reg <= `PULLUP_E_RST; // [RULE13]
		end
		else
		begin
			port_e_func <= next_e_func_w[1:0];
			port_e_dir <= next_e_dir_w[1:0];
			port_e_data <= next_e_data_w[1:0];
			port_e_pullup_reg <= next_e_pull_w[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// input synchronisers

	logic [7:0] d_clean;
	logic [1:0] e_clean;

	pin_input_sync #(
		.WIDTH(`PORT_D_WIDTH)
	) u_sync_d (
		.clk(clk),
		.arst_n(arst_n),
		.raw(port_d_pin_in),
		.clean(d_clean)
	);

	pin_input_sync #(
		.WIDTH(`PORT_E_WIDTH)
	) u_sync_e (
		.clk(clk),
		.arst_n(arst_n),
		.raw(port_e_pin_in),
		.clean(e_clean)
	);

	////////////////////////////////////////////////////////////////////////
	// port D pin selection

	// chip selects drive while the bus runs; idle, the drive bit decides
	// whether they float or hold their deasserted level
	wire cs_drive = external_memory_interface.bus_active | external_memory_interface.idle_bus_drive_bit; // [RULE4]

	wire [7:0] next_d_out;
	wire [7:0] next_d_oe_n;

	genvar i;
	generate
		for (i = 0; i < `CS_COUNT; i++)
		begin : g_cs_pin
			// peripheral mode carries chip select i+2
			assign next_d_out[i] = port_d_func[i] ?
				external_memory_interface.select_n[i] : port_d_data[i]; // [RULE2]
			assign next_d_oe_n[i] = port_d_func[i] ?
				~cs_drive : ~port_d_dir[i]; // [RULE1] [RULE4]
		end
	endgenerate

	// port D 6 carries serial one transmit, always driven in that mode
	assign next_d_out[`D_TX_BIT] = port_d_func[`D_TX_BIT] ?
		serial_one_tx : port_d_data[`D_TX_BIT]; // [RULE10]
	assign next_d_oe_n[`D_TX_BIT] = port_d_func[`D_TX_BIT] ?
		1'b0 : ~port_d_dir[`D_TX_BIT]; // [RULE10]

	// port D 7 is a pure input while it serves serial one receive
	assign next_d_out[`D_RX_BIT] = port_d_func[`D_RX_BIT] ?
		1'b0 : port_d_data[`D_RX_BIT]; // [RULE11]
	assign next_d_oe_n[`D_RX_BIT] = port_d_func[`D_RX_BIT] ?
		1'b1 : ~port_d_dir[`D_RX_BIT]; // [RULE11]

	////////////////////////////////////////////////////////////////////////
	// port E pin selection

	wire [1:0] next_e_out;
	wire [1:0] next_e_oe_n;

	// port E 0 carries serial zero transmit
	assign next_e_out[`E_TX_BIT] = port_e_func[`E_TX_BIT] ?
		serial_zero_tx : port_e_data[`E_TX_BIT]; // [RULE7]
	assign next_e_oe_n[`E_TX_BIT] = port_e_func[`E_TX_BIT] ?
		1'b0 : ~port_e_dir[`E_TX_BIT]; // [RULE7]

	// port E 1 is a pure input while it serves serial zero receive
	assign next_e_out[`E_RX_BIT] = port_e_func[`E_RX_BIT] ?
		1'b0 : port_e_data[`E_RX_BIT]; // [RULE8]
	assign next_e_oe_n[`E_RX_BIT] = port_e_func[`E_RX_BIT] ?
		1'b1 : ~port_e_dir[`E_RX_BIT]; // [RULE8]

	////////////////////////////////////////////////////////////////////////
	// receive routing

	// a receiver whose pin is in gpio mode sees an idle (high) line,
	// so it never decodes stray gpio traffic as start bits
	wire next_zero_rx = port_e_func[`E_RX_BIT] ?
		e_clean[`E_RX_BIT] : 1'b1; // [RULE8]
	wire next_one_rx = port_d_func[`D_RX_BIT] ?
		d_clean[`D_RX_BIT] : 1'b1; // [RULE11]

	////////////////////////////////////////////////////////////////////////
	// registered pad outputs
	// during reset every pad floats with its pull-up on; this costs one
	// cycle of latency on every pin but keeps the pads glitch free

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			port_d_pin_out <= 8'h00;
			port_d_pin_oe_n <= 8'hff; // [RULE10] [RULE11]
			port_d_pin_pullup_en <= 8'hff;
			port_e_pin_out <= 2'h0;
			port_e_pin_oe_n <= 2'h3; // [RULE7] [RULE8]
			port_e_pin_pullup_en <= 2'h3;
		end
		else
		begin
			port_d_pin_out <= next_d_out;
			port_d_pin_oe_n <= next_d_oe_n;
			port_d_pin_pullup_en <= port_d_pullup_reg; // [RULE6] [RULE12]
			port_e_pin_out <= next_e_out;
			port_e_pin_oe_n <= next_e_oe_n;
			port_e_pin_pullup_en <= port_e_pullup_reg; // [RULE9]
		end
	end

	// receive lines and gpio read-back levels
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			serial_zero_rx <= 1'b1;
			serial_one_rx <= 1'b1;
			port_d_gpio_level <= 8'hff;
			port_e_gpio_level <= 2'h3;
		end
		else
		begin
			serial_zero_rx <= next_zero_rx;
			serial_one_rx <= next_one_rx;
			port_d_gpio_level <= d_clean; // [RULE1]
			port_e_gpio_level <= e_clean;
		end
	end

endmodule // port_d_e_pin_function_mux

`default_nettype wire

// ===== bench/pin_mux_props.sv
/*
 * checker for the pin function multiplexer's pad outputs.
 * assumes: bound to the top module; one clock, async active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none

module pin_mux_props
	import pin_mux_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire cfg_write_t cfg,
	input wire emi_cs_t external_memory_interface,
	input wire logic serial_zero_tx,
	input wire logic serial_one_tx,
	input wire logic [7:0] port_d_pin_out,
	input wire logic [7:0] port_d_pin_oe_n,
	input wire logic [7:0] port_d_pin_pullup_en,
	input wire logic [1:0] port_e_pin_out,
	input wire logic [1:0] port_e_pin_oe_n,
	input wire logic [1:0] port_e_pin_pullup_en,
	input wire logic [7:0] port_d_func,
	input wire logic [1:0] port_e_func
);
	logic out_of_reset;

	// the release edge still resets the design, so checking starts one
	// edge later; otherwise the reset pad state reads as a failure
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			out_of_reset <= 1'b0;
		else
			out_of_reset <= 1'b1;
	end

	default clocking @(posedge clk);
	endclocking
	default disable iff (!arst_n || !out_of_reset);

	// pull-up writes reach the pads two edges after the take
	AST_PULL_D: assert property (
		(cfg.en && cfg.target == TGT_PULL_D) |-> ##2
		port_d_pin_pullup_en == $past(cfg.data, 2))
		else $error("pull d");
	AST_PULL_E: assert property (
		(cfg.en && cfg.target == TGT_PULL_E) |-> ##2
		port_e_pin_pullup_en == $past(cfg.data[1:0], 2))
		else $error("pull e");
	// chip selects follow the memory interface; on idle they float unless the drive bit is set
	AST_CS_OUT: assert property (
		port_d_func[5:0] == 6'h3f |=>
		port_d_pin_out[5:0] == $past(external_memory_interface.select_n))
		else $error("cs out");
	AST_CS_OE: assert property (
		port_d_func[0] |=> port_d_pin_oe_n[0] ==
		$past(!(external_memory_interface.bus_active || external_memory_interface.idle_bus_drive_bit)))
		else $error("cs oe");
	// serial transmit pins drive, receive pins float
	AST_TX_ONE: assert property (
		port_d_func[6] |=> !port_d_pin_oe_n[6] &&
		port_d_pin_out[6] == $past(serial_one_tx))
		else $error("tx one");
	AST_TX_ZERO: assert property (
		port_e_func[0] |=> !port_e_pin_oe_n[0] &&
		port_e_pin_out[0] == $past(serial_zero_tx))
		else $error("tx zero");
	AST_RX_ONE: assert property (
		port_d_func[7] |=> port_d_pin_oe_n[7])
		else $error("rx one driven");
	AST_RX_ZERO: assert property (
		port_e_func[1] |=> port_e_pin_oe_n[1])
		else $error("rx zero driven");
endmodule // pin_mux_props

////////////////////////////////////////////////////////////////////////
bind port_d_e_pin_function_mux pin_mux_props pin_mux_props_i (.clk, .arst_n,
	.cfg, .external_memory_interface, .serial_zero_tx, .serial_one_tx, .port_d_pin_out,
	.port_d_pin_oe_n, .port_d_pin_pullup_en, .port_e_pin_out,
	.port_e_pin_oe_n, .port_e_pin_pullup_en, .port_d_func, .port_e_func);

`default_nettype wire

// ===== bench/pin_pad_model.sv
/*
 * pad and far-side model: resolves a pin from the block, the far side
 * and the pull-up.
 * assumes: far side drives only where ext_en is high.
 */
`timescale 1ns/1ps
`default_nettype none

module pin_pad_model #(
	parameter int WIDTH = 8
) (
	input wire logic clk,
	input wire logic [WIDTH-1:0] out,
	input wire logic [WIDTH-1:0] oe_n,
	input wire logic [WIDTH-1:0] pullup_en,
	input wire logic [WIDTH-1:0] ext_en,
	input wire logic [WIDTH-1:0] ext_val,
	output logic [WIDTH-1:0] pin
);
	logic [WIDTH-1:0] held = '0;
	wire [WIDTH-1:0] driven = ~oe_n | ext_en | pullup_en;

	// remember the last resolved level while something sets the pin;
	// a floating pin without pull-up then shows its inverse, steadily
	always_ff @(posedge clk)
	begin
		held <= (driven & pin) | (~driven & held);
	end
	// block wins, then far side, then pull-up
	assign pin = (~oe_n & out) | (oe_n & ext_en & ext_val)
		| (oe_n & ~ext_en & pullup_en) | (~driven & ~held);
endmodule // pin_pad_model

`default_nettype wire

// ===== bench/testbench.sv
/*
 * self-checking bench for the pin function multiplexer.
 * assumes: design package compiled first; checker bound separately.
 */
`timescale 1ns/1ps
`default_nettype none

`define CHK(n, e, g) \
	begin \
		num_checks++; \
		if ((g) !== (e)) \
		begin \
			bad_count++; \
			$display("MISMATCH %s exp %h got %h", n, e, g); \
		end \
	end

module testbench;
	import pin_mux_pkg::*;

	logic clk = 1'b0;
	logic arst_n = 1'b0;
	cfg_write_t cfg = '0;
	emi_cs_t external_memory_interface = '0;
	logic serial_zero_tx = 1'b0;
	logic serial_one_tx = 1'b1;
	logic serial_zero_rx, serial_one_rx;
	logic [7:0] port_d_pin_in, port_d_pin_out, port_d_pin_oe_n;
	logic [7:0] port_d_pin_pullup_en, port_d_gpio_level, port_d_func;
	logic [7:0] port_d_pullup_reg;
	logic [1:0] port_e_pin_in, port_e_pin_out, port_e_pin_oe_n;
	logic [1:0] port_e_pin_pullup_en, port_e_gpio_level, port_e_func;
	logic [1:0] port_e_pullup_reg;
	logic [7:0] d_ext_en = '0;
	logic [7:0] d_ext_val = '0;
	logic [1:0] e_ext_en = '0;
	logic [1:0] e_ext_val = '0;
	int bad_count = 0;
	int num_checks = 0;
	// grouped views keep the compare lines short
	wire [9:0] oe_n_all = {port_d_pin_oe_n, port_e_pin_oe_n};
	wire [9:0] pull_all = {port_d_pin_pullup_en, port_e_pin_pullup_en};
	wire [9:0] pull_regs = {port_d_pullup_reg, port_e_pullup_reg};
	wire [1:0] tx_pins = {port_d_pin_out[6], port_e_pin_out[0]};

	////////////////////////////////////////////////////////////////////
	// design and the pads on both ports
	port_d_e_pin_function_mux port_d_e_pin_function_mux_i (.clk, .arst_n,
		.cfg, .external_memory_interface, .serial_zero_tx, .serial_one_tx, .serial_zero_rx,
		.serial_one_rx, .port_d_pin_in, .port_d_pin_out, .port_d_pin_oe_n,
		.port_d_pin_pullup_en, .port_e_pin_in, .port_e_pin_out,
		.port_e_pin_oe_n, .port_e_pin_pullup_en, .port_d_gpio_level,
		.port_e_gpio_level, .port_d_func, .port_d_pullup_reg, .port_e_func,
		.port_e_pullup_reg);
	pin_pad_model #(.WIDTH(8)) pad_d_i (.clk, .out(port_d_pin_out),
		.oe_n(port_d_pin_oe_n), .pullup_en(port_d_pin_pullup_en),
		.ext_en(d_ext_en), .ext_val(d_ext_val), .pin(port_d_pin_in));
	pin_pad_model #(.WIDTH(2)) pad_e_i (.clk, .out(port_e_pin_out),
		.oe_n(port_e_pin_oe_n), .pullup_en(port_e_pin_pullup_en),
		.ext_en(e_ext_en), .ext_val(e_ext_val), .pin(port_e_pin_in));

	// 50 MHz clock
	initial
	begin
		forever #10 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////
	// fixed waits only: every latency here is fixed, so nothing can hang
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// one configuration write, strobe dropped on the next edge
	task automatic wr(input cfg_target_t t, input logic [7:0] d);
		@(posedge clk);
		cfg <= '{en: 1'b1, target: t, data: d};
		@(posedge clk);
		cfg.en <= 1'b0;
	endtask

	// serial pins after reset, then tx flips and rx pins pulled low
	task automatic serial_pins();
		wait_n(2);
		`CHK("oe_n", 10'h2fe, oe_n_all)
		`CHK("tx", 2'h2, tx_pins)
		@(posedge clk);
		serial_one_tx <= 1'b0;
		serial_zero_tx <= 1'b1;
		d_ext_en <= 8'h80;
		e_ext_en <= 2'h2;
		wait_n(7);
		`CHK("tx flip", 2'h1, tx_pins)
		`CHK("rx", 2'h0, {serial_one_rx, serial_zero_rx})
		`CHK("e level", 2'h1, port_e_gpio_level)
	endtask

	// per-pin direction; far side drives high only on the input pins
	task automatic gpio_dir();
		wr(TGT_DIR_D, 8'h15);
		wr(TGT_DATA_D, 8'h25);
		d_ext_en <= 8'h2a;
		d_ext_val <= 8'h2a;
		wait_n(7);
		`CHK("gpio oe_n", 6'h2a, port_d_pin_oe_n[5:0])
		`CHK("gpio out", 6'h25, port_d_pin_out[5:0])
		`CHK("gpio level", 6'h2f, port_d_gpio_level[5:0])
	endtask

	// chip selects while active, idle floating, idle driven
	task automatic chip_selects();
		wr(TGT_FUNC_D, 8'hff);
		external_memory_interface <= '{select_n: 6'h2a, bus_active: 1'b1,
			idle_bus_drive_bit: 1'b0};
		wait_n(2);
		`CHK("cs out", 6'h2a, port_d_pin_out[5:0])
		`CHK("cs oe active", 6'h00, port_d_pin_oe_n[5:0])
		@(posedge clk);
		external_memory_interface.bus_active <= 1'b0;
		wait_n(2);
		`CHK("cs oe float", 6'h3f, port_d_pin_oe_n[5:0])
		@(posedge clk);
		external_memory_interface.idle_bus_drive_bit <= 1'b1;
		wait_n(2);
		`CHK("cs oe drive", 6'h00, port_d_pin_oe_n[5:0])
	endtask

	// pull-up disables; upper bits of the port E pull-up write are dropped
	task automatic pullups();
		wr(TGT_PULL_D, 8'h3e);
		wr(TGT_PULL_E, 8'hfe);
		wait_n(2);
		`CHK("pull reg", 10'h0fa, pull_regs)
		`CHK("pull pad", 10'h0fa, pull_all)
	endtask

	// port E back to gpio: receiver idles high, pins follow gpio regs
	task automatic port_e_gpio();
		wr(TGT_FUNC_E, 8'h00);
		wr(TGT_DIR_E, 8'h01);
		wr(TGT_DATA_E, 8'hfe);
		wait_n(2);
		`CHK("e func", 2'h0, port_e_func)
		`CHK("e oe_n", 2'h2, port_e_pin_oe_n)
		`CHK("e out", 2'h2, port_e_pin_out)
		`CHK("zero rx idle", 1'b1, serial_zero_rx)
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////
	// reset state, then the scenarios in turn
	initial
	begin
		@(posedge clk);
		#1;
		`CHK("func", 10'h303, {port_d_func, port_e_func})
		`CHK("pull regs", 10'h3ff, pull_regs)
		`CHK("rst oe_n", 10'h3ff, oe_n_all)
		`CHK("rst pull", 10'h3ff, pull_all)
		`CHK("rst rx", 2'h3, {serial_one_rx, serial_zero_rx})
		@(posedge clk);
		arst_n <= 1'b1;
		serial_pins();
		gpio_dir();
		chip_selects();
		pullups();
		port_e_gpio();
		final_report();
	end
endmodule // testbench

`default_nettype wire
